// ===== hdl/abs_ctl_end.sv
// Central controller end of the array barrier link.
// Assumes the link vectors are driven by every processor slot.
`timescale 1ns/1ps
`include "abs_defines.svh"

module abs_ctl_end (
    // Clock and reset
    input  wire logic                       CLK_SYS,
    input  wire logic                       RST_N,
    // Link to the array
    abs_link_if.ctl                         lk,
    // Command and broadcast requests
    input  wire logic                       CMD_VALID,
    input  wire logic [`ABS_CMD_W-1:0]      CMD_CODE,
    input  wire logic                       BCAST_VALID,
    input  wire logic [`ABS_BYTE_W-1:0]     BCAST_DATA,
    // Synchronised instruction requests
    input  wire logic                       SYNC_START,
    input  wire abs_pkg::abs_sync_e         SYNC_KIND,
    input  wire logic [`ABS_CNT_W-1:0]      READ_COUNT,
    input  wire logic                       SW_SET,
    output logic                            SYNC_BUSY,
    output logic                            SYNC_DONE,
    output logic                            EM_READ,
    // Array status
    output logic                            ALL_READY,
    output logic                            ANY_ENABLED,
    output logic [`ABS_BYTE_W-1:0]          HARVEST_DATA,
    output logic                            HARVEST_STB,
    output logic                            PROC_IRQ
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    abs_pkg::abs_ctl_s s_q;
    abs_pkg::abs_ctl_s s_d;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic all_rdy;
        logic [`ABS_BYTE_W-1:0] hv;
        all_rdy = &(lk.arrive | ~lk.enabled);
        hv      = '0;
        // Strobed harvest bytes merge as a wired OR in the fan-in tree.
        for (int i = 0; i < `ABS_NPROC; i++) begin
            if (lk.harvest_stb[i]) begin
                hv = hv | lk.harvest[i];
            end
        end
        s_d             = s_q;
        s_d.go          = 1'b0;
        s_d.cmd_stb     = CMD_VALID;
        s_d.bcast_stb   = BCAST_VALID;
        s_d.em_read     = 1'b0;
        s_d.done        = 1'b0;
        s_d.all_ready   = all_rdy;
        s_d.any_enabled = |lk.enabled;
        s_d.irq         = |lk.irq;
        s_d.harvest_stb = |lk.harvest_stb;
        s_d.harvest     = hv;
        if (CMD_VALID) begin
            s_d.cmd = CMD_CODE;
        end
        if (BCAST_VALID) begin
            s_d.bcast = BCAST_DATA;
        end

        case (s_q.st)
            abs_pkg::C_IDLE: begin
                if (SYNC_START) begin
                    s_d.busy       = 1'b1;
                    s_d.reads_left = READ_COUNT;
                    if (SYNC_KIND == abs_pkg::SYNC_FETCH) begin
                        s_d.st = abs_pkg::C_SETUP;
                    end else begin
                        s_d.st = abs_pkg::C_BARRIER;
                    end
                end
            end
            abs_pkg::C_SETUP: begin
                if (SW_SET) begin
                    s_d.armed = 1'b1;
                    s_d.st    = abs_pkg::C_ARMED;
                end
            end
            abs_pkg::C_ARMED: begin
                if (all_rdy) begin
                    s_d.cnt = `ABS_CNT_W'(`ABS_ADDR_LOAD_CYC - 1);
                    s_d.st  = abs_pkg::C_LOAD;
                end
            end
            abs_pkg::C_LOAD: begin
                if (s_q.cnt != `ABS_CNT_ZERO) begin
                    s_d.cnt = s_q.cnt - `ABS_CNT_ONE;
                end else if (s_q.reads_left == `ABS_CNT_ZERO) begin
                    s_d.cnt = `ABS_CNT_W'(`ABS_GO_GAP_CYC - 1);
                    s_d.st  = abs_pkg::C_GAP;
                end else begin
                    s_d.st = abs_pkg::C_READ;
                end
            end
            abs_pkg::C_READ: begin
                s_d.em_read    = 1'b1;
                s_d.reads_left = s_q.reads_left - `ABS_CNT_ONE;
                if (s_q.reads_left == `ABS_CNT_ONE) begin
                    s_d.cnt = `ABS_CNT_W'(`ABS_GO_GAP_CYC - 1);
                    s_d.st  = abs_pkg::C_GAP;
                end
            end
            abs_pkg::C_GAP: begin
                // The gap lets the last word cross the switch before release.
                if (s_q.cnt != `ABS_CNT_ZERO) begin
                    s_d.cnt = s_q.cnt - `ABS_CNT_ONE;
                end else begin
                    s_d.go    = 1'b1;
                    s_d.armed = 1'b0;
                    s_d.busy  = 1'b0;
                    s_d.done  = 1'b1;
                    s_d.st    = abs_pkg::C_IDLE;
                end
            end
            abs_pkg::C_BARRIER: begin
                if (all_rdy) begin
                    s_d.go   = 1'b1;
                    s_d.busy = 1'b0;
                    s_d.done = 1'b1;
                    s_d.st   = abs_pkg::C_IDLE;
                end
            end
            default: begin
                s_d.st = abs_pkg::C_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            s_q    <= '0;
            s_q.st <= abs_pkg::C_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign lk.armed     = s_q.armed;
    assign lk.go        = s_q.go;
    assign lk.cmd       = s_q.cmd;
    assign lk.cmd_stb   = s_q.cmd_stb;
    assign lk.bcast     = s_q.bcast;
    assign lk.bcast_stb = s_q.bcast_stb;

    assign SYNC_BUSY    = s_q.busy;
    assign SYNC_DONE    = s_q.done;
    assign EM_READ      = s_q.em_read;
    assign ALL_READY    = s_q.all_ready;
    assign ANY_ENABLED  = s_q.any_enabled;
    assign HARVEST_DATA = s_q.harvest;
    assign HARVEST_STB  = s_q.harvest_stb;
    assign PROC_IRQ     = s_q.irq;

endmodule

// ===== hdl/abs_defines.svh
// Constants shared by both ends of the array barrier link.
// Assumes inclusion by bare name from the package and both ends.
`ifndef ABS_DEFINES_SVH
`define ABS_DEFINES_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define ABS_NPROC        512
`define ABS_CMD_W        4
`define ABS_BYTE_W       8
`define ABS_ADDR_W       16
`define ABS_WORD_W       48
`define ABS_PNUM_W       9
`define ABS_PC_W         13
`define ABS_CNT_W        8

// ----------------------------------------------------------------
// Values
// ----------------------------------------------------------------
`define ABS_PNUM_ONE     9'h001
`define ABS_CNT_ONE      8'h01
`define ABS_CNT_ZERO     8'h00

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define ABS_CMD_LOAD_PC  4'h1
`define ABS_CMD_SET_EN   4'h2
`define ABS_CMD_CLR_EN   4'h3
`define ABS_CMD_HARVEST  4'h4

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ABS_CLK_PERIOD_NS 25
`define ABS_ADDR_LOAD_NS  120
`define ABS_GO_GAP_NS     120
`define ABS_ADDR_LOAD_CYC \
    ((`ABS_ADDR_LOAD_NS + `ABS_CLK_PERIOD_NS - 1) / `ABS_CLK_PERIOD_NS)
`define ABS_GO_GAP_CYC \
    ((`ABS_GO_GAP_NS + `ABS_CLK_PERIOD_NS - 1) / `ABS_CLK_PERIOD_NS)

`endif

// ===== hdl/abs_link_if.sv
// Link between the central controller and the processor array.
// Assumes each processor instance drives only its own bit of the vectors.
`timescale 1ns/1ps
`include "abs_defines.svh"

interface abs_link_if;

    // ------------------------------------------------------------
    // Controller to all processors
    // ------------------------------------------------------------
    logic                       armed;
    logic                       go;
    logic [`ABS_CMD_W-1:0]      cmd;
    logic                       cmd_stb;
    logic [`ABS_BYTE_W-1:0]     bcast;
    logic                       bcast_stb;

    // ------------------------------------------------------------
    // Each processor to controller
    // ------------------------------------------------------------
    logic [`ABS_NPROC-1:0]      arrive;
    logic [`ABS_NPROC-1:0]      enabled;
    logic [`ABS_NPROC-1:0]      irq;
    logic [`ABS_BYTE_W-1:0]     harvest [`ABS_NPROC];
    logic [`ABS_NPROC-1:0]      harvest_stb;

    modport ctl (
        output armed, go, cmd, cmd_stb, bcast, bcast_stb,
        input  arrive, enabled, irq, harvest, harvest_stb
    );

    modport dev (
        input  armed, go, cmd, cmd_stb, bcast, bcast_stb,
        output arrive, enabled, irq, harvest, harvest_stb
    );

endinterface

// ===== hdl/abs_pkg.sv
// Types shared by both ends of the array barrier link.
// Assumes abs_defines.svh is on the include path.
`include "abs_defines.svh"

package abs_pkg;

    // ------------------------------------------------------------
    // Processor instruction classes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_OTHER,
        OP_BLOCK_FETCH,
        OP_BLOCK_STORE,
        OP_NEIGHBOUR_SHIFT,
        OP_BARRIER_WAIT,
        OP_HALT
    } abs_op_e;

    typedef enum logic [1:0] {
        SYNC_FETCH,
        SYNC_WAIT
    } abs_sync_e;

    typedef enum logic [1:0] {
        D_IDLE,
        D_FETCH,
        D_WAIT
    } abs_dev_st_e;

    typedef enum logic [2:0] {
        C_IDLE,
        C_SETUP,
        C_ARMED,
        C_LOAD,
        C_READ,
        C_GAP,
        C_BARRIER
    } abs_ctl_st_e;

    // ------------------------------------------------------------
    // Processor state
    // ------------------------------------------------------------
    typedef struct packed {
        abs_dev_st_e                st;
        logic                       ready;
        logic                       done;
        logic                       enabled;
        logic                       arrive;
        logic                       sent;
        logic [`ABS_ADDR_W-1:0]     sw_addr;
        logic                       sw_addr_stb;
        logic [`ABS_WORD_W-1:0]     sw_wr_word;
        logic                       sw_wr_stb;
        logic [`ABS_WORD_W-1:0]     fetch_word;
        logic                       fetch_stb;
        logic [`ABS_PC_W-1:0]       pc;
        logic [2*`ABS_BYTE_W-1:0]   pc_shift;
        logic [`ABS_BYTE_W-1:0]     bcast_byte;
        logic                       bcast_stb;
        logic [`ABS_BYTE_W-1:0]     harvest;
        logic                       harvest_stb;
        logic                       irq;
        logic [`ABS_PNUM_W-1:0]     proc_no;
    } abs_dev_s;

    // ------------------------------------------------------------
    // Controller state
    // ------------------------------------------------------------
    typedef struct packed {
        abs_ctl_st_e                st;
        logic                       armed;
        logic                       go;
        logic [`ABS_CMD_W-1:0]      cmd;
        logic                       cmd_stb;
        logic [`ABS_BYTE_W-1:0]     bcast;
        logic                       bcast_stb;
        logic [`ABS_CNT_W-1:0]      cnt;
        logic [`ABS_CNT_W-1:0]      reads_left;
        logic                       em_read;
        logic                       busy;
        logic                       done;
        logic                       all_ready;
        logic                       any_enabled;
        logic [`ABS_BYTE_W-1:0]     harvest;
        logic                       harvest_stb;
        logic                       irq;
    } abs_ctl_s;

endpackage

// ===== hdl/abs_proc_end.sv
// Synchronisation end of one array processor.
// Assumes one instance per array slot, PROC_IDX picking its link bit.
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`include "abs_defines.svh"

module abs_proc_end #(
    parameter int PROC_IDX = 0
) (
    // Clock and reset
    input  wire logic                       CLK_SYS,
    input  wire logic                       RST_N,
    // Link to the controller
    abs_link_if.dev                         lk,
    // Instruction issue
    input  wire logic                       INSTR_VALID,
    input  wire abs_pkg::abs_op_e           INSTR_OP,
    input  wire logic                       INSTR_SKIP,
    input  wire logic [`ABS_ADDR_W-1:0]     INSTR_ADDR,
    input  wire logic [`ABS_WORD_W-1:0]     STORE_WORD,
    output logic                            INSTR_READY,
    output logic                            INSTR_DONE,
    // Transposition switch paths
    output logic [`ABS_ADDR_W-1:0]          SW_ADDR,
    output logic                            SW_ADDR_STB,
    output logic [`ABS_WORD_W-1:0]          SW_WR_WORD,
    output logic                            SW_WR_STB,
    input  wire logic [`ABS_WORD_W-1:0]     SW_RD_WORD,
    input  wire logic                       SW_RD_STB,
    output logic [`ABS_WORD_W-1:0]          FETCH_WORD,
    output logic                            FETCH_STB,
    // Command and byte paths
    output logic [`ABS_PC_W-1:0]            PC,
    output logic                            ENABLED,
    output logic [`ABS_BYTE_W-1:0]          BCAST_BYTE,
    output logic                            BCAST_STB,
    input  wire logic [`ABS_BYTE_W-1:0]     HARVEST_BYTE,
    input  wire logic                       IRQ_REQ,
    // Numbering
    input  wire logic [`ABS_PNUM_W-1:0]     BACKPLANE_NO,
    input  wire logic                       SPARE_SHIFT,
    output logic [`ABS_PNUM_W-1:0]          PROC_NO
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    abs_pkg::abs_dev_s s_q;
    abs_pkg::abs_dev_s s_d;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d             = s_q;
        s_d.done        = 1'b0;
        s_d.sw_addr_stb = 1'b0;
        s_d.sw_wr_stb   = 1'b0;
        s_d.fetch_stb   = 1'b0;
        s_d.bcast_stb   = 1'b0;
        s_d.harvest_stb = 1'b0;
        s_d.irq         = IRQ_REQ;

        // The spare sits below this slot, so close the gap it leaves.
        if (SPARE_SHIFT) begin
            s_d.proc_no = BACKPLANE_NO - `ABS_PNUM_ONE;
        end else begin
            s_d.proc_no = BACKPLANE_NO;
        end

        if (lk.bcast_stb) begin
            s_d.bcast_byte = lk.bcast;
            s_d.bcast_stb  = 1'b1;
            s_d.pc_shift   = {s_q.pc_shift[`ABS_BYTE_W-1:0], lk.bcast};
        end

        if (lk.cmd_stb) begin
            case (lk.cmd)
                `ABS_CMD_LOAD_PC: begin
                    s_d.pc      = s_q.pc_shift[`ABS_PC_W-1:0];
                    s_d.enabled = 1'b1;
                end
                `ABS_CMD_SET_EN: begin
                    s_d.enabled = 1'b1;
                end
                `ABS_CMD_CLR_EN: begin
                    if (s_q.enabled) begin
                        s_d.enabled = 1'b0;
                    end
                end
                `ABS_CMD_HARVEST: begin
                    if (s_q.enabled) begin
                        s_d.harvest     = HARVEST_BYTE;
                        s_d.harvest_stb = 1'b1;
                    end
                end
                default: begin
                    s_d.harvest_stb = 1'b0;
                end
            endcase
        end

        case (s_q.st)
            abs_pkg::D_IDLE: begin
                if (INSTR_VALID && s_q.ready) begin
                    case (INSTR_OP)
                        abs_pkg::OP_BLOCK_FETCH: begin
                            if (s_q.enabled && !INSTR_SKIP) begin
                                s_d.arrive  = 1'b1;
                                s_d.sw_addr = INSTR_ADDR;
                                s_d.sent    = 1'b0;
                                s_d.ready   = 1'b0;
                                s_d.st      = abs_pkg::D_FETCH;
                            end else begin
                                s_d.done = 1'b1;
                            end
                        end
                        abs_pkg::OP_BLOCK_STORE: begin
                            if (s_q.enabled && !INSTR_SKIP) begin
                                s_d.sw_wr_word = STORE_WORD;
                                s_d.sw_wr_stb  = 1'b1;
                            end
                            s_d.done = 1'b1;
                        end
                        abs_pkg::OP_BARRIER_WAIT: begin
                            if (s_q.enabled) begin
                                s_d.arrive = 1'b1;
                                s_d.ready  = 1'b0;
                                s_d.st     = abs_pkg::D_WAIT;
                            end else begin
                                s_d.done = 1'b1;
                            end
                        end
                        abs_pkg::OP_HALT: begin
                            s_d.enabled = 1'b0;
                            s_d.done    = 1'b1;
                        end
                        default: begin
                            // Shift and local work finish here; the shift
                            // network itself lives outside this block.
                            s_d.done = 1'b1;
                        end
                    endcase
                end
            end
            abs_pkg::D_FETCH: begin
                if (lk.armed && !s_q.sent) begin
                    s_d.sw_addr_stb = 1'b1;
                    s_d.sent        = 1'b1;
                end
                if (SW_RD_STB) begin
                    s_d.fetch_word = SW_RD_WORD;
                    s_d.fetch_stb  = 1'b1;
                end
                if (lk.go) begin
                    s_d.arrive = 1'b0;
                    s_d.ready  = 1'b1;
                    s_d.done   = 1'b1;
                    s_d.st     = abs_pkg::D_IDLE;
                end
            end
            abs_pkg::D_WAIT: begin
                if (lk.go) begin
                    s_d.arrive = 1'b0;
                    s_d.ready  = 1'b1;
                    s_d.done   = 1'b1;
                    s_d.st     = abs_pkg::D_IDLE;
                end
            end
            default: begin
                s_d.st = abs_pkg::D_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            s_q       <= '0;
            s_q.st    <= abs_pkg::D_IDLE;
            s_q.ready <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign lk.arrive[PROC_IDX]      = s_q.arrive;
    assign lk.enabled[PROC_IDX]     = s_q.enabled;
    assign lk.irq[PROC_IDX]         = s_q.irq;
    assign lk.harvest[PROC_IDX]     = s_q.harvest;
    assign lk.harvest_stb[PROC_IDX] = s_q.harvest_stb;

    assign INSTR_READY = s_q.ready;
    assign INSTR_DONE  = s_q.done;
    assign SW_ADDR     = s_q.sw_addr;
    assign SW_ADDR_STB = s_q.sw_addr_stb;
    assign SW_WR_WORD  = s_q.sw_wr_word;
    assign SW_WR_STB   = s_q.sw_wr_stb;
    assign FETCH_WORD  = s_q.fetch_word;
    assign FETCH_STB   = s_q.fetch_stb;
    assign PC          = s_q.pc;
    assign ENABLED     = s_q.enabled;
    assign BCAST_BYTE  = s_q.bcast_byte;
    assign BCAST_STB   = s_q.bcast_stb;
    assign PROC_NO     = s_q.proc_no;

endmodule

// ===== tb/abs_link_asserts.sv
// Concurrent checks on the link between the controller and processor slot 0.
// Assumes every other slot bit is tied low and one clock serves both ends.
`timescale 1ns/1ps
`include "abs_defines.svh"

module abs_link_asserts (
    // Clock and reset
    input wire logic                  CLK_SYS,
    input wire logic                  RST_N,
    // Link
    input wire logic                  armed,
    input wire logic                  go,
    input wire logic [`ABS_CMD_W-1:0] cmd,
    input wire logic                  cmd_stb,
    input wire logic [`ABS_NPROC-1:0] arrive,
    input wire logic [`ABS_NPROC-1:0] enabled
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    a_go_single: assert property (go |=> !go) else $error("go too wide");
    a_go_ready: assert property (go |-> &(arrive | ~enabled))
        else $error("go early");
    a_armed_drop: assert property ($fell(armed) |-> go || $past(go))
        else $error("armed fell early");
    a_arrive_drop: assert property (go |-> ##1 !arrive[0])
        else $error("arrive held");
    a_arrive_en: assert property ($rose(arrive[0]) |-> enabled[0])
        else $error("arrive while off");
    a_load_en: assert property (cmd_stb && cmd == `ABS_CMD_LOAD_PC |=> enabled[0])
        else $error("load left off");
    a_clr_en: assert property (cmd_stb && cmd == `ABS_CMD_CLR_EN |=> !enabled[0])
        else $error("clear ignored");
    a_en_rise: assert property ($rose(enabled[0]) |-> $past(cmd_stb) &&
        ($past(cmd) == `ABS_CMD_LOAD_PC || $past(cmd) == `ABS_CMD_SET_EN))
        else $error("enable rose alone");
endmodule

// ===== tb/array_barrier_sync_bench.sv
// Bench for the barrier link: controller end facing processor slot 0.
// Assumes the design files compile first; other slots are tied low.
`timescale 1ns/1ps
`include "abs_defines.svh"

module array_barrier_sync_bench;
    // ------------------------------------------------------------
    // Wiring, stimulus and checking
    // ------------------------------------------------------------
    logic CLK_SYS, RST_N, INSTR_VALID, INSTR_SKIP, SW_RD_STB, IRQ_REQ, SPARE_SHIFT;
    logic CMD_VALID, BCAST_VALID, SYNC_START, SW_SET, INSTR_READY, INSTR_DONE, ENABLED;
    logic SW_ADDR_STB, SW_WR_STB, FETCH_STB, BCAST_STB, SYNC_BUSY, SYNC_DONE, EM_READ;
    logic ALL_READY, ANY_ENABLED, HARVEST_STB, PROC_IRQ;
    logic [15:0] INSTR_ADDR, SW_ADDR;
    logic [47:0] STORE_WORD, SW_WR_WORD, SW_RD_WORD, FETCH_WORD, r, w, q[$];
    logic [12:0] PC;
    logic [8:0]  BACKPLANE_NO, PROC_NO;
    logic [7:0]  BCAST_BYTE, HARVEST_BYTE, BCAST_DATA, READ_COUNT, HARVEST_DATA;
    logic [3:0]  CMD_CODE;
    logic [31:0] s = 32'h0000_ca33;
    abs_pkg::abs_op_e   INSTR_OP;
    abs_pkg::abs_sync_e SYNC_KIND;
    int fails = 0, compares = 0, cycles = 0, words = 0;
    abs_link_if lk ();
    for (genvar k = 1; k < `ABS_NPROC; k++) begin : g_tie
        assign lk.arrive[k] = 1'b0;
        assign lk.enabled[k] = 1'b0;
        assign lk.irq[k] = 1'b0;
        assign lk.harvest_stb[k] = 1'b0;
        assign lk.harvest[k] = 8'h00;
    end
    abs_ctl_end i_abs_ctl_end (.*);
    abs_proc_end #(.PROC_IDX(0)) i_abs_proc_end (.*);
    abs_link_asserts i_abs_link_asserts (.CLK_SYS, .RST_N, .armed(lk.armed), .go(lk.go),
        .cmd(lk.cmd), .cmd_stb(lk.cmd_stb), .arrive(lk.arrive), .enabled(lk.enabled));
    function automatic logic [47:0] xs();
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return {s[15:0], s};
    endfunction
    task automatic chk(input logic [47:0] g, input logic [47:0] e);
        compares++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic final_report;
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic send(input logic c, input logic [7:0] v);
        @(posedge CLK_SYS);
        CMD_VALID <= c;
        BCAST_VALID <= !c;
        CMD_CODE <= v[3:0];
        BCAST_DATA <= v;
        if (!c) q.push_back(48'(v));
        @(posedge CLK_SYS);
        {CMD_VALID, BCAST_VALID} <= 2'b00;
        repeat (3) @(posedge CLK_SYS);
    endtask
    task automatic sync(input abs_pkg::abs_sync_e k);
        @(posedge CLK_SYS);
        SYNC_START <= 1'b1;
        SYNC_KIND <= k;
        READ_COUNT <= 8'(xs() & 48'h3) + 8'h01;
        @(posedge CLK_SYS);
        SYNC_START <= 1'b0;
        SW_SET <= k == abs_pkg::SYNC_FETCH;
        @(posedge CLK_SYS);
        SW_SET <= 1'b0;
    endtask
    task automatic instr(input abs_pkg::abs_op_e o, input logic k);
        @(posedge CLK_SYS);
        {INSTR_VALID, INSTR_SKIP} <= {1'b1, k};
        INSTR_OP <= o;
        r = xs();
        if (o == abs_pkg::OP_BLOCK_FETCH && !k) q.push_back(48'(r[15:0]));
        if (o == abs_pkg::OP_BLOCK_STORE && !k) q.push_back(r);
        {INSTR_ADDR, STORE_WORD} <= {r[15:0], r};
        @(posedge CLK_SYS);
        INSTR_VALID <= 1'b0;
        for (int i = 0; i < 300 && INSTR_DONE !== 1'b1; i++) @(posedge CLK_SYS);
        chk(48'(INSTR_DONE), 48'h1);
    endtask
    initial begin
        CLK_SYS = 1'b0;
        forever #12.5 CLK_SYS = ~CLK_SYS;
    end
    always @(posedge CLK_SYS) begin
        w = xs();
        SW_RD_WORD <= w;
        SW_RD_STB <= EM_READ;
        if (EM_READ === 1'b1) q.push_back(w);
        if (++cycles == 20000) begin
            fails++;
            final_report;
        end
    end
    always @(posedge CLK_SYS) begin
        if (FETCH_STB === 1'b1) begin
            chk(FETCH_WORD, q.pop_front());
            words++;
        end
        if (HARVEST_STB === 1'b1) chk(48'(HARVEST_DATA), q.pop_front());
        if (BCAST_STB === 1'b1) chk(48'(BCAST_BYTE), q.pop_front());
        if (SW_ADDR_STB === 1'b1) chk(48'(SW_ADDR), q.pop_front());
        if (SW_WR_STB === 1'b1) chk(SW_WR_WORD, q.pop_front());
        if (SYNC_DONE === 1'b1) chk(48'({lk.go, SYNC_BUSY, ALL_READY}), 48'h5);
    end
    initial begin
        {RST_N, INSTR_VALID, INSTR_SKIP, SW_RD_STB, IRQ_REQ, SPARE_SHIFT} = '0;
        {CMD_VALID, BCAST_VALID, SYNC_START, SW_SET, CMD_CODE, BCAST_DATA} = '0;
        {INSTR_ADDR, STORE_WORD, SW_RD_WORD, HARVEST_BYTE, READ_COUNT, BACKPLANE_NO} = '0;
        INSTR_OP = abs_pkg::OP_OTHER;
        SYNC_KIND = abs_pkg::SYNC_WAIT;
        repeat (8) @(posedge CLK_SYS);
        RST_N <= 1'b1;
        chk(48'({INSTR_READY, ENABLED}), 48'h2);
        repeat (4) begin
            r = xs();
            {BACKPLANE_NO, SPARE_SHIFT} <= r[9:0];
            repeat (2) @(posedge CLK_SYS);
            chk(48'(PROC_NO), 48'(BACKPLANE_NO - 9'(SPARE_SHIFT)));
        end
        send(1'b1, 8'(`ABS_CMD_CLR_EN));
        chk(48'(ENABLED), 48'h0);
        r = xs();
        send(1'b0, r[15:8]);
        send(1'b0, r[7:0]);
        send(1'b1, 8'(`ABS_CMD_LOAD_PC));
        chk(48'({ENABLED, PC}), 48'({1'b1, r[12:0]}));
        HARVEST_BYTE <= r[23:16];
        q.push_back(48'(r[23:16]));
        IRQ_REQ <= 1'b1;
        send(1'b1, 8'(`ABS_CMD_HARVEST));
        chk(48'({ANY_ENABLED, PROC_IRQ}), 48'h3);
        sync(abs_pkg::SYNC_WAIT);
        chk(48'(SYNC_BUSY), 48'h1);
        instr(abs_pkg::OP_BARRIER_WAIT, 1'b0);
        sync(abs_pkg::SYNC_FETCH);
        instr(abs_pkg::OP_BLOCK_FETCH, 1'b0);
        chk(48'({lk.armed, SYNC_BUSY, q.size()}), 48'h0);
        chk(48'(words), 48'(READ_COUNT));
        instr(abs_pkg::OP_BLOCK_FETCH, 1'b1);
        chk(48'(lk.arrive[0]), 48'h0);
        instr(abs_pkg::OP_HALT, 1'b0);
        chk(48'(ENABLED), 48'h0);
        send(1'b1, 8'(`ABS_CMD_SET_EN));
        chk(48'(ENABLED), 48'h1);
        instr(abs_pkg::OP_BLOCK_STORE, 1'b0);
        instr(abs_pkg::OP_BLOCK_STORE, 1'b1);
        instr(abs_pkg::OP_NEIGHBOUR_SHIFT, 1'b1);
        chk(48'(q.size()), 48'h0);
        final_report;
    end
endmodule
